// file: src/pss_pkg.sv
// Constants shared by the program sequencer, stack and indirect addressing block.
// Assumes a single 125 MHz clock and word-indexed Avalon-MM register access.
`default_nettype none
package pss_pkg;
  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [4:0] IDX_WINDOW  = 5'h00;
  localparam logic [4:0] IDX_STACK   = 5'h01;
  localparam logic [4:0] IDX_PCL     = 5'h02;
  localparam logic [4:0] IDX_STATUS  = 5'h03;
  localparam logic [4:0] IDX_POINTER = 5'h04;
  localparam logic [4:0] IDX_TRIM    = 5'h05;
  localparam logic [4:0] IDX_PCHI    = 5'h06;
  localparam logic [4:0] IDX_RAM_LO  = 5'h07;
  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         PAGE_BIT     = 5;
  localparam int         BANK_BIT     = 5;
  localparam logic [7:0] TRIM4_RESET  = 8'h70;
  localparam logic [7:0] TRIM6_RESET  = 8'h80;
  localparam logic [7:0] TRIM4_MASK   = 8'hf0;
  localparam logic [7:0] TRIM6_MASK   = 8'hfc;
  localparam logic [7:0] PTR_SMALL_HI = 8'he0;
  localparam logic [7:0] PTR_LARGE_HI = 8'hc0;
  localparam logic [7:0] PAGE_RESET   = 8'h00;
  localparam int         STACK_W      = 12;
  // Bus answer latency: one wait cycle before every acknowledge.
  localparam int         WAIT_CYCLES  = 1;
  // ----------------------------------------------------------------
  // Sequencing operations presented by the instruction decoder
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PSS_OP_STEP,
    PSS_OP_JUMP,
    PSS_OP_CALL,
    PSS_OP_RETURN
  } pss_op_t;
endpackage
`default_nettype wire

// file: src/pss_sequencer.sv
// Program counter, two-level return stack, indirect pointer/window and oscillator trim.
// Assumes the instruction decoder runs on sys_clk and issues one op per seq_step pulse,
// and that data-file accesses of the core arrive over the Avalon-MM slave port.
`default_nettype none
module pss_sequencer #(
  parameter int         PC_W      = 10,
  parameter bit         LARGE_MEM = 1'b1,
  parameter bit         TRIM_SIX  = 1'b1
) (
  input  wire logic                sys_clk,
  input  wire logic                nrst,
  input  wire logic                seq_step,
  input  wire pss_pkg::pss_op_t    seq_op,
  input  wire logic [8:0]          seq_imm,
  input  wire logic [6:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic [31:0]              avs_readdata,
  output logic                     avs_waitrequest,
  output logic [PC_W-1:0]          instr_pointer,
  output logic                     w_load,
  output logic [7:0]               w_data,
  output logic [7:0]               osc_trim
);
  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam logic [7:0] TRIM_MASK  = TRIM_SIX ? pss_pkg::TRIM6_MASK : pss_pkg::TRIM4_MASK;
  localparam logic [7:0] TRIM_RESET = TRIM_SIX ? pss_pkg::TRIM6_RESET : pss_pkg::TRIM4_RESET;
  localparam logic [7:0] PTR_HI     = LARGE_MEM ? pss_pkg::PTR_LARGE_HI : pss_pkg::PTR_SMALL_HI;

  logic [pss_pkg::STACK_W-1:0] stack_one;
  logic [pss_pkg::STACK_W-1:0] stack_two;
  logic [7:0]                  pointer;
  logic [7:0]                  status;
  logic [7:0]                  ram [0:63];
  logic [PC_W-1:0]             pc_inc;

  assign pc_inc = instr_pointer + {{(PC_W-1){1'b0}}, 1'b1};

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic       req;
  logic       take;
  logic [4:0] dir_idx;
  logic       via_window;
  logic [4:0] eff_idx;
  logic       eff_bank;
  logic [5:0] ram_addr;
  logic       wr_en;
  logic [7:0] wr_byte;

  assign req        = avs_read | avs_write;
  // The request is taken at the edge where waitrequest is seen low.
  assign take       = req & ~avs_waitrequest;
  assign dir_idx    = avs_address[6:2];
  assign via_window = (dir_idx == pss_pkg::IDX_WINDOW);
  // The window redirects to the pointer's target location.
  assign eff_idx    = via_window ? pointer[4:0] : dir_idx;
  assign eff_bank   = via_window & LARGE_MEM & pointer[pss_pkg::BANK_BIT];
  assign ram_addr   = {eff_bank, eff_idx};
  assign wr_en      = take & avs_write & avs_byteenable[0];
  assign wr_byte    = avs_writedata[7:0];

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else if (req && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [7:0] rd_byte;

  always_comb begin
    rd_byte = 8'h00;
    unique case (eff_idx)
      // Pointer zero through the window reads the window itself.
      pss_pkg::IDX_WINDOW:  rd_byte = 8'h00;
      pss_pkg::IDX_STACK:   rd_byte = stack_one[7:0];
      pss_pkg::IDX_PCL:     rd_byte = instr_pointer[7:0];
      pss_pkg::IDX_STATUS:  rd_byte = status;
      pss_pkg::IDX_POINTER: rd_byte = pointer | PTR_HI;
      pss_pkg::IDX_TRIM:    rd_byte = osc_trim & TRIM_MASK;
      pss_pkg::IDX_PCHI:    rd_byte = 8'(instr_pointer >> 8);
      default:              rd_byte = ram[ram_addr];
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= {24'h000000, rd_byte};
    end
  end

  // ----------------------------------------------------------------
  // Special function registers
  // ----------------------------------------------------------------
  logic wr_pcl;
  assign wr_pcl = wr_en && (eff_idx == pss_pkg::IDX_PCL);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= pss_pkg::PAGE_RESET;
    end else if (wr_en && eff_idx == pss_pkg::IDX_STATUS) begin
      status <= wr_byte & (8'h01 << pss_pkg::PAGE_BIT);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pointer <= PTR_HI;
    end else if (wr_en && eff_idx == pss_pkg::IDX_POINTER) begin
      pointer <= wr_byte | PTR_HI;
    end
  end

  // The trim value goes straight to the oscillator; larger is faster.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_trim <= TRIM_RESET & TRIM_MASK;
    end else if (wr_en && eff_idx == pss_pkg::IDX_TRIM) begin
      osc_trim <= wr_byte & TRIM_MASK;
    end
  end

  // General file registers have no reset. Window writes at pointer zero
  // fall on the window index, which has no storage.
  always_ff @(posedge sys_clk) begin
    if (wr_en && eff_idx >= pss_pkg::IDX_RAM_LO) begin
      ram[ram_addr] <= wr_byte;
    end
  end

  // ----------------------------------------------------------------
  // Program counter
  // ----------------------------------------------------------------
  logic page;
  assign page = status[pss_pkg::PAGE_BIT];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      instr_pointer <= '1;
    end else if (wr_pcl) begin
      // A low-latch write is itself an instruction result and wins.
      instr_pointer <= PC_W'({page, 1'b0, wr_byte});
    end else if (seq_step) begin
      unique case (seq_op)
        pss_pkg::PSS_OP_JUMP:   instr_pointer <= PC_W'({page, seq_imm});
        pss_pkg::PSS_OP_CALL:   instr_pointer <= PC_W'({page, 1'b0, seq_imm[7:0]});
        pss_pkg::PSS_OP_RETURN: instr_pointer <= stack_one[PC_W-1:0];
        pss_pkg::PSS_OP_STEP:   instr_pointer <= pc_inc;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Return stack
  // ----------------------------------------------------------------
  // No reset: the stack survives every reset, and no overflow or
  // underflow flag exists, so excess calls silently drop level two.
  always_ff @(posedge sys_clk) begin
    if (seq_step && !wr_pcl) begin
      if (seq_op == pss_pkg::PSS_OP_CALL) begin
        stack_two <= stack_one;
        stack_one <= pss_pkg::STACK_W'(pc_inc);
      end else if (seq_op == pss_pkg::PSS_OP_RETURN) begin
        stack_one <= stack_two;
      end
    end
  end

  // ----------------------------------------------------------------
  // Working register load on return
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      w_load <= 1'b0;
      w_data <= 8'h00;
    end else begin
      w_load <= seq_step && !wr_pcl && seq_op == pss_pkg::PSS_OP_RETURN;
      if (seq_step && !wr_pcl && seq_op == pss_pkg::PSS_OP_RETURN) begin
        w_data <= seq_imm[7:0];
      end
    end
  end

endmodule
`default_nettype wire

// file: verification/pss_seq_properties.sv
// Checker bound to the sequencer: counter loads, return literal and bus timing.
// Assumes one clock domain; a low nrst disables every check but the reset one.
`default_nettype none
module pss_seq_properties #(
  parameter int PC_W = 10
) (
  input wire logic             sys_clk,
  input wire logic             nrst,
  input wire logic             seq_step,
  input wire pss_pkg::pss_op_t seq_op,
  input wire logic [8:0]       seq_imm,
  input wire logic [6:0]       avs_address,
  input wire logic             avs_read,
  input wire logic             avs_write,
  input wire logic [31:0]      avs_writedata,
  input wire logic [3:0]       avs_byteenable,
  input wire logic             avs_waitrequest,
  input wire logic [PC_W-1:0]  instr_pointer,
  input wire logic             w_load,
  input wire logic [7:0]       w_data,
  input wire logic [7:0]       osc_trim
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  logic pcl_wr;
  // A bus write of the low latch beats a decoder op, so ops are judged without one.
  assign pcl_wr = avs_write && !avs_waitrequest && avs_byteenable[0] &&
                  avs_address[6:2] == pss_pkg::IDX_PCL;
  sequence op_taken(pss_pkg::pss_op_t o);
    seq_step && seq_op == o && !pcl_wr;
  endsequence
  chk_step_adds_one: assert property (op_taken(pss_pkg::PSS_OP_STEP) |=>
    instr_pointer == $past(instr_pointer) + 1'b1) else $error("Counter did not step.");
  chk_idle_pc_holds: assert property (!seq_step && !pcl_wr |=>
    $stable(instr_pointer)) else $error("Counter moved with no op.");
  chk_jump_loads_imm: assert property (op_taken(pss_pkg::PSS_OP_JUMP) |=>
    instr_pointer[8:0] == $past(seq_imm)) else $error("Jump target wrong.");
  chk_call_clears_b8: assert property (op_taken(pss_pkg::PSS_OP_CALL) |=>
    instr_pointer[8:0] == {1'b0, $past(seq_imm[7:0])}) else $error("Call target wrong.");
  chk_latch_write_pc: assert property (pcl_wr |=>
    instr_pointer[8:0] == {1'b0, $past(avs_writedata[7:0])}) else $error("Latch write lost.");
  chk_return_literal: assert property (op_taken(pss_pkg::PSS_OP_RETURN) |=>
    w_load && w_data == $past(seq_imm[7:0])) else $error("Return literal wrong.");
  chk_reset_all_ones: assert property (disable iff (1'b0) !nrst [*2] |->
    &instr_pointer) else $error("Counter not all ones in reset.");
  chk_one_wait_cycle: assert property ((avs_read || avs_write) && avs_waitrequest |=>
    !avs_waitrequest) else $error("Bus answer late.");
  chk_trim_low_zero: assert property (osc_trim[1:0] == 2'b00)
    else $error("Trim low bits set.");
endmodule
bind pss_sequencer pss_seq_properties #(.PC_W(PC_W)) chk_u (
  .sys_clk(sys_clk), .nrst(nrst), .seq_step(seq_step), .seq_op(seq_op),
  .seq_imm(seq_imm), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_waitrequest(avs_waitrequest), .instr_pointer(instr_pointer), .w_load(w_load),
  .w_data(w_data), .osc_trim(osc_trim));
`default_nettype wire

// file: verification/tb_program_sequencer_stack_indirect.sv
// Testbench for the sequencer: decoder ops and Avalon-MM register accesses.
// Assumes the large-memory, six-bit trim build with a ten-bit counter.
`default_nettype none
module tb_program_sequencer_stack_indirect;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Stimulus and checks
  // ----------------------------------------
  localparam pss_pkg::pss_op_t STEP = pss_pkg::PSS_OP_STEP;
  localparam pss_pkg::pss_op_t JUMP = pss_pkg::PSS_OP_JUMP;
  localparam pss_pkg::pss_op_t CALL = pss_pkg::PSS_OP_CALL;
  localparam pss_pkg::pss_op_t RET  = pss_pkg::PSS_OP_RETURN;
  logic             sys_clk = 1'b0;
  logic             nrst = 1'b0;
  logic             seq_step = 1'b0;
  pss_pkg::pss_op_t seq_op = STEP;
  logic [8:0]       seq_imm = 9'h000;
  logic [6:0]       avs_address = 7'h00;
  logic             avs_read = 1'b0;
  logic             avs_write = 1'b0;
  logic [31:0]      avs_writedata = 32'h0;
  logic [31:0]      avs_readdata;
  logic             avs_waitrequest;
  logic [9:0]       instr_pointer;
  logic             w_load;
  logic [7:0]       w_data;
  logic [7:0]       osc_trim;
  logic [7:0]       rd;
  int               err_total = 0;
  int               n_tests = 0;
  pss_sequencer #(.PC_W(10)) dut_u (
    .sys_clk(sys_clk), .nrst(nrst), .seq_step(seq_step), .seq_op(seq_op),
    .seq_imm(seq_imm), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .instr_pointer(instr_pointer), .w_load(w_load), .w_data(w_data), .osc_trim(osc_trim));
  always #4 sys_clk = ~sys_clk;
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // The request stands until the rising edge at which waitrequest is seen low; read data
  // is taken at that same edge and the request is released right after it.
  task automatic bus(input logic wr, input logic [4:0] idx, input logic [7:0] wd);
    bit got = 1'b0;
    @(posedge sys_clk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h0, wd};
    avs_read <= ~wr;
    avs_write <= wr;
    for (int i = 0; i < 20 && !got; i++) begin
      @(posedge sys_clk);
      got = avs_waitrequest === 1'b0;
      if (got) rd = avs_readdata[7:0];
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (!got) begin
      err_total++;
      report_and_stop();
    end
  endtask
  task automatic wr(input logic [4:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask
  task automatic rdchk(input logic [4:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    check(rd, exp);
  endtask
  task automatic op(input pss_pkg::pss_op_t o, input logic [8:0] imm, input logic [9:0] exp);
    @(posedge sys_clk);
    seq_step <= 1'b1;
    seq_op <= o;
    seq_imm <= imm;
    @(posedge sys_clk);
    seq_step <= 1'b0;
    @(negedge sys_clk);
    check(instr_pointer, exp);
  endtask
  task automatic do_reset;
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (4) @(negedge sys_clk);
  endtask
  initial begin
    do_reset();
    check(instr_pointer, 16'h3ff);
    check(osc_trim, pss_pkg::TRIM6_RESET);
    rdchk(5'h04, 8'hc0);
    rdchk(5'h03, 8'h00);
    op(STEP, 9'h000, 10'h000);
    op(STEP, 9'h000, 10'h001);
    op(JUMP, 9'h1a5, 10'h1a5);
    wr(5'h03, 8'h20);
    op(JUMP, 9'h0f3, 10'h2f3);
    op(CALL, 9'h155, 10'h255);
    rdchk(5'h01, 8'hf4);
    rdchk(5'h06, 8'h02);
    op(CALL, 9'h066, 10'h266);
    op(CALL, 9'h077, 10'h277);
    op(RET, 9'h03c, 10'h267);
    check(w_load, 1'b1);
    check(w_data, 8'h3c);
    op(RET, 9'h0a1, 10'h256);
    op(RET, 9'h000, 10'h256);
    do_reset();
    check(instr_pointer, 16'h3ff);
    rdchk(5'h01, 8'h56);
    rdchk(5'h03, 8'h00);
    wr(5'h03, 8'h20);
    wr(5'h02, 8'h9a);
    @(negedge sys_clk);
    check(instr_pointer, 16'h29a);
    rdchk(5'h02, 8'h9a);
    wr(5'h07, 8'h10);
    wr(5'h08, 8'h0a);
    wr(5'h04, 8'h07);
    rdchk(5'h00, 8'h10);
    wr(5'h04, 8'h08);
    rdchk(5'h00, 8'h0a);
    rdchk(5'h04, 8'hc8);
    wr(5'h00, 8'h5e);
    rdchk(5'h08, 8'h5e);
    wr(5'h04, 8'h28);
    wr(5'h00, 8'h33);
    rdchk(5'h00, 8'h33);
    rdchk(5'h08, 8'h5e);
    wr(5'h04, 8'h1f);
    wr(5'h00, 8'h6b);
    rdchk(5'h1f, 8'h6b);
    wr(5'h04, 8'h00);
    wr(5'h00, 8'hff);
    rdchk(5'h00, 8'h00);
    rdchk(5'h1f, 8'h6b);
    wr(5'h05, 8'hff);
    rdchk(5'h05, 8'hfc);
    check(osc_trim, 8'hfc);
    report_and_stop();
  end
endmodule
`default_nettype wire
